// ---- verilog/button_event_defines.svh ----
// constants shared by the button event device and its bus controller
// assumes a 50 MHz system clock and 24-bit forward frames on the link
`ifndef BUTTON_EVENT_DEFINES_SVH
`define BUTTON_EVENT_DEFINES_SVH

// timing
`define CLK_FREQ_HZ        50000000
`define TICK_MS            20
`define TICK_CYCLES        ((`TICK_MS * `CLK_FREQ_HZ) / 1000)

// event information codes, 10 bits
`define EV_RELEASED        10'h000
`define EV_PRESSED         10'h001
`define EV_SHORT           10'h002
`define EV_DOUBLE          10'h005
`define EV_LONG_START      10'h009
`define EV_LONG_REPEAT     10'h00B
`define EV_LONG_STOP       10'h00C
`define EV_FREE            10'h00E
`define EV_STUCK           10'h00F

// forward frames
`define FRAME_W            24
`define DTR0_PREFIX        16'hC130
`define CMD_RESET          24'hFFFE10
`define CMD_SET_SHORT      24'hFFFF00
`define CMD_SET_DOUBLE     24'hFFFF01
`define CMD_SET_REPEAT     28'hFFFFF02
`define CMD_SET_FILTER     28'hFFFFF68

// settings after reset, in 20 ms ticks except the filter bit mask
`define SHORT_RESET        8'h32
`define DOUBLE_RESET       8'h19
`define REPEAT_RESET       8'h0A
`define FILTER_RESET       8'h3C
`define STUCK_TICKS        16'h03E8

// lamp commands issued by the controller
`define LAMP_LAST_ACTIVE   16'hFF0A
`define LAMP_OFF           16'hFF00
`define LAMP_RECALL_MIN    16'hFF06
`define LAMP_UP            16'hFF01

// controller register offsets and the twice bit of command writes
`define REG_CMD            12'h000
`define REG_STATUS         12'h004
`define REG_EVENT          12'h008
`define REG_LAMP           12'h00C
`define CMD_TWICE_BIT      24

`endif

// ---- verilog/button_event_pkg.sv ----
// types shared by the button event device and its bus controller
// assumes the defines header is compiled alongside
`default_nettype none
package button_event_pkg;
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_HELD    = 6'h02,
		ST_GAP     = 6'h04,
		ST_SECOND  = 6'h08,
		ST_LONG    = 6'h10,
		ST_STUCK   = 6'h20
	} key_state_type;

	typedef enum logic [1:0] {
		TX_IDLE   = 2'h1,
		TX_REPEAT = 2'h2
	} tx_state_type;
endpackage
`default_nettype wire

// ---- verilog/event_link_if.sv ----
// link between the bus controller and the button event device
// assumes both ends share one clock; frames are one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "button_event_defines.svh"
interface event_link_if;
	logic                  frame_valid;
	logic [`FRAME_W-1:0]   frame;
	logic                  ev_valid;
	logic [9:0]            ev_code;
	logic                  ev_ready;

	modport device (input frame_valid, input frame, output ev_valid, output ev_code,
		input ev_ready);
	modport controller (output frame_valid, output frame, input ev_valid,
		input ev_code, output ev_ready);
endinterface
`default_nettype wire

// ---- verilog/button_event_device.sv ----
// push-button event detector: classifies key presses, sends event codes
// assumes I_CLK at 50 MHz and a key input already synchronous to it
//
// Behaviour
// - one 1-bit key input, 1 is pressed
// - send notification whenever an event condition holds
// - 10-bit codes, released 000, pressed 001
// - short press after full double window released
// - double press when second press inside window
// - long start after key held short threshold
// - long repeat each repeat interval while held
// - long stop when held long press ends
// - stuck after long hold, free on release
// - thresholds are setting times 20 ms tick
// - reset command acts only when received twice
// - DTR0 then set-short twice stores threshold
// - DTR0 then set-double twice stores window
// - DTR0 then set-repeat twice stores interval
// - DTR0 then set-filter twice stores filter
// - example filter passes short, double, long start and long repeat events
// - controller handles events, device sends no lamps
// - controller maps events onto broadcast lamp commands
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "button_event_defines.svh"
module button_event_device
	import button_event_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int STUCK_TICKS = `STUCK_TICKS
) (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_SRST,
	// key
	input  wire logic        I_TOUCH_KEY_INPUT,
	// link
	event_link_if.device     link,
	// settings seen by the user side
	output logic [7:0]       O_SHORT_SETTING,
	output logic [7:0]       O_DOUBLE_SETTING,
	output logic [7:0]       O_REPEAT_SETTING,
	output logic [7:0]       O_EVENT_FILTER
);
	localparam int NEV = 9;

	logic [19:0]             tick_cnt_q;
	logic                    tick;
	logic                    key_q;
	key_state_type           state_q;
	logic [7:0]              cnt_q;
	logic [15:0]             hold_q;
	logic [7:0]              cnt_inc;
	logic [7:0]              short_q;
	logic [7:0]              double_q;
	logic [7:0]              repeat_q;
	logic [7:0]              filter_q;
	logic [7:0]              dtr0_q;
	logic [`FRAME_W-1:0]     prev_q;
	logic                    armed_q;
	logic                    twice;
	logic [NEV-1:0]          raise;
	logic [NEV-1:0]          allowed;
	logic [NEV-1:0]          pend_q;
	logic [NEV-1:0]          pend_d;
	logic [NEV-1:0]          sent;
	logic [3:0]              head;
	logic [9:0]              code_q;
	logic                    busy_q;

	// maps a pending slot onto its event code
	function automatic logic [9:0] slot_code(input logic [3:0] idx);
		case (idx)
			4'h0: slot_code = `EV_RELEASED;
			4'h1: slot_code = `EV_PRESSED;
			4'h2: slot_code = `EV_SHORT;
			4'h3: slot_code = `EV_DOUBLE;
			4'h4: slot_code = `EV_LONG_START;
			4'h5: slot_code = `EV_LONG_REPEAT;
			4'h6: slot_code = `EV_LONG_STOP;
			4'h7: slot_code = `EV_FREE;
			default: slot_code = `EV_STUCK;
		endcase
	endfunction

	// 20 ms tick divider
	always_ff @(posedge I_CLK) begin
		if (I_SRST || tick) begin
			tick_cnt_q <= 20'h00000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 20'h00001;
		end
	end
	assign tick = (tick_cnt_q == 20'(TICK_CYCLES - 1));

	// key sampled once per tick
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			key_q <= 1'b0;
		end else if (tick) begin
			key_q <= I_TOUCH_KEY_INPUT;
		end
	end

	// a config command counts when it equals the frame just before it
	assign twice = link.frame_valid && armed_q && (link.frame == prev_q);

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			prev_q  <= '0;
			armed_q <= 1'b0;
		end else if (link.frame_valid) begin
			prev_q  <= link.frame;
			armed_q <= !twice; // a third copy starts a new pair
		end
	end

	// DTR0 and stored settings
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			dtr0_q   <= 8'h00;
			short_q  <= `SHORT_RESET;
			double_q <= `DOUBLE_RESET;
			repeat_q <= `REPEAT_RESET;
			filter_q <= `FILTER_RESET;
		end else if (link.frame_valid && link.frame[23:8] == `DTR0_PREFIX) begin
			dtr0_q <= link.frame[7:0];
		end else if (twice) begin
			if (link.frame == `CMD_RESET) begin
				short_q  <= `SHORT_RESET;
				double_q <= `DOUBLE_RESET;
				repeat_q <= `REPEAT_RESET;
				filter_q <= `FILTER_RESET;
			end else if (link.frame == `CMD_SET_SHORT) begin
				short_q <= dtr0_q;
			end else if (link.frame == `CMD_SET_DOUBLE) begin
				double_q <= dtr0_q;
			end else if (link.frame == 24'(`CMD_SET_REPEAT)) begin // only low 24 bits travel
				repeat_q <= dtr0_q;
			end else if (link.frame == 24'(`CMD_SET_FILTER)) begin
				filter_q <= dtr0_q;
			end
		end
	end

	assign cnt_inc = cnt_q + 8'h01;

	// press classification, advanced on ticks only
	always_ff @(posedge I_CLK) begin
		raise <= '0;
		if (I_SRST) begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			hold_q  <= 16'h0000;
		end else if (tick) begin
			cnt_q  <= cnt_inc;
			hold_q <= key_q ? hold_q + 16'h0001 : 16'h0000;
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 8'h00;
					if (key_q) begin
						raise[1] <= 1'b1;
						state_q  <= ST_HELD;
					end
				end
				ST_HELD: begin
					if (!key_q) begin
						raise[0] <= 1'b1;
						cnt_q    <= 8'h00;
						state_q  <= ST_GAP;
					end else if (cnt_inc >= short_q) begin
						raise[4] <= 1'b1;
						cnt_q    <= 8'h00;
						state_q  <= ST_LONG;
					end
				end
				ST_GAP: begin
					if (key_q) begin
						raise[1] <= 1'b1;
						raise[3] <= 1'b1;
						state_q  <= ST_SECOND;
					end else if (cnt_inc >= double_q) begin
						raise[2] <= 1'b1;
						state_q  <= ST_IDLE;
					end
				end
				ST_SECOND: begin
					if (!key_q) begin
						raise[0] <= 1'b1;
						state_q  <= ST_IDLE;
					end
				end
				ST_LONG: begin
					if (!key_q) begin
						raise[6] <= 1'b1;
						raise[0] <= 1'b1;
						state_q  <= ST_IDLE;
					end else if (hold_q + 16'h0001 >= 16'(STUCK_TICKS)) begin
						raise[8] <= 1'b1;
						state_q  <= ST_STUCK;
					end else if (cnt_inc >= repeat_q) begin
						raise[5] <= 1'b1;
						cnt_q    <= 8'h00;
					end
				end
				ST_STUCK: begin
					if (!key_q) begin
						raise[7] <= 1'b1;
						raise[0] <= 1'b1;
						state_q  <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// filter: bit n enables slot n, bit 7 covers stuck and free
	assign allowed = {filter_q[7], filter_q};

	// lowest pending slot goes out first
	always_comb begin
		head = 4'h0;
		for (int i = NEV - 1; i >= 0; i--) begin
			if (pend_q[i]) begin
				head = 4'(i);
			end
		end
	end

	// a slot is cleared only when its code was really offered, so the gap cycle drops nothing
	assign sent   = (link.ev_valid && link.ev_ready) ? (NEV'(1) << head) : '0;
	assign pend_d = (pend_q & ~sent) | (raise & allowed); // new event wins over clear

	// pending events and the outgoing notification
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			pend_q <= '0;
			busy_q <= 1'b0;
			code_q <= `EV_RELEASED;
		end else begin
			pend_q <= pend_d;
			if (!busy_q || link.ev_ready) begin
				busy_q <= |(pend_q & ~sent);
				code_q <= slot_code(head);
			end
		end
	end

	// the head slot is dropped only when its code is taken
	assign link.ev_valid = busy_q && pend_q[head] && (slot_code(head) == code_q);
	assign link.ev_code  = code_q;

	assign O_SHORT_SETTING  = short_q;
	assign O_DOUBLE_SETTING = double_q;
	assign O_REPEAT_SETTING = repeat_q;
	assign O_EVENT_FILTER   = filter_q;
endmodule
`default_nettype wire

// ---- verilog/event_bus_controller.sv ----
// bus controller end: sends frames from APB writes, turns events into lamp commands
// assumes an APB master on the same clock; the device end answers on the link
`timescale 1ns/1ps
`default_nettype none
`include "button_event_defines.svh"
module event_bus_controller
	import button_event_pkg::*;
(
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_SRST,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// link
	event_link_if.controller link,
	// lamp command out
	output logic             O_LAMP_VALID,
	output logic [15:0]      O_LAMP_CMD
);
	tx_state_type            tx_q;
	logic [`FRAME_W-1:0]     frame_q;
	logic                    fvalid_q;
	logic                    seen_q;
	logic [9:0]              event_q;
	logic [15:0]             lamp_q;
	logic                    lamp_v_q;
	logic                    wr;
	logic                    rd;
	logic                    mapped;
	logic                    take;

	assign wr     = PSEL && PENABLE && PWRITE;
	assign rd     = PSEL && PENABLE && !PWRITE;
	assign mapped = (PADDR == `REG_CMD) || (PADDR == `REG_STATUS) ||
		(PADDR == `REG_EVENT) || (PADDR == `REG_LAMP);
	assign take   = link.ev_valid && link.ev_ready;

	// frame sender: one strobe, or two with one idle cycle between
	always_ff @(posedge I_CLK) begin
		fvalid_q <= 1'b0;
		if (I_SRST) begin
			tx_q    <= TX_IDLE;
			frame_q <= '0;
		end else if (tx_q == TX_REPEAT && !fvalid_q) begin
			fvalid_q <= 1'b1;
			tx_q     <= TX_IDLE;
		end else if (tx_q == TX_IDLE && wr && PADDR == `REG_CMD) begin
			frame_q  <= PWDATA[`FRAME_W-1:0];
			fvalid_q <= 1'b1;
			tx_q     <= PWDATA[`CMD_TWICE_BIT] ? TX_REPEAT : TX_IDLE;
		end
	end

	// received events and the lamp command for short, double, long start and long repeat
	always_ff @(posedge I_CLK) begin
		lamp_v_q <= 1'b0;
		if (I_SRST) begin
			seen_q  <= 1'b0;
			event_q <= `EV_RELEASED;
			lamp_q  <= 16'h0000;
		end else begin
			if (wr && PADDR == `REG_STATUS && PWDATA[1]) begin
				seen_q <= 1'b0;
			end
			if (take) begin
				seen_q  <= 1'b1; // set wins over clear
				event_q <= link.ev_code;
				lamp_v_q <= 1'b1;
				if (link.ev_code == `EV_SHORT) begin
					lamp_q <= `LAMP_LAST_ACTIVE;
				end else if (link.ev_code == `EV_DOUBLE) begin
					lamp_q <= `LAMP_OFF;
				end else if (link.ev_code == `EV_LONG_START) begin
					lamp_q <= `LAMP_RECALL_MIN;
				end else if (link.ev_code == `EV_LONG_REPEAT) begin
					lamp_q <= `LAMP_UP;
				end else begin
					lamp_v_q <= 1'b0;
				end
			end
		end
	end

	// read mux
	always_comb begin
		PRDATA = 32'h00000000;
		if (!rd) begin
			PRDATA = 32'h00000000;
		end else if (PADDR == `REG_CMD) begin
			PRDATA = {8'h00, frame_q};
		end else if (PADDR == `REG_STATUS) begin
			PRDATA = {30'h0, seen_q, tx_q != TX_IDLE || fvalid_q};
		end else if (PADDR == `REG_EVENT) begin
			PRDATA = {22'h0, event_q};
		end else if (PADDR == `REG_LAMP) begin
			PRDATA = {16'h0000, lamp_q};
		end
	end

	assign PREADY          = 1'b1;
	assign PSLVERR         = PSEL && PENABLE && !mapped;
	assign link.frame_valid = fvalid_q;
	assign link.frame      = frame_q;
	assign link.ev_ready   = !I_SRST;
	assign O_LAMP_VALID    = lamp_v_q;
	assign O_LAMP_CMD      = lamp_q;
endmodule
`default_nettype wire

// ---- dv/push_button_event_detector_asserts.sv ----
// checker on the link between the bus controller and the button event device
// assumes it is instantiated beside the link, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "button_event_defines.svh"
module push_button_event_detector_asserts (
	// clock and reset
	input  wire logic                I_CLK,
	input  wire logic                I_SRST,
	// link
	input  wire logic                frame_valid,
	input  wire logic [`FRAME_W-1:0] frame,
	input  wire logic                ev_valid,
	input  wire logic [9:0]          ev_code,
	input  wire logic                ev_ready
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_SRST);
	logic       take;
	logic [9:0] last_q;
	// one event handed over this cycle
	assign take = ev_valid && ev_ready;
	// last event taken, to judge the order of events
	always_ff @(posedge I_CLK) begin
		if (I_SRST)
			last_q <= 10'h3FF;
		else if (take)
			last_q <= ev_code;
	end
	property p_ev_legal;
		ev_valid |-> ev_code inside {10'h000, 10'h001, 10'h002, 10'h005, 10'h009, 10'h00B,
			10'h00C, 10'h00E, 10'h00F};
	endproperty
	property p_ev_gap;
		take |=> !ev_valid;
	endproperty
	property p_frame_pulse;
		frame_valid |=> !frame_valid;
	endproperty
	property p_twice_same;
		frame_valid ##2 frame_valid |-> frame == $past(frame, 2);
	endproperty
	property p_reset_quiet;
		$fell(I_SRST) |-> !ev_valid && !frame_valid;
	endproperty
	property p_repeat_order;
		take && ev_code == `EV_LONG_REPEAT |-> last_q inside {`EV_LONG_START, `EV_LONG_REPEAT};
	endproperty
	property p_stop_order;
		take && ev_code == `EV_LONG_STOP |-> last_q == `EV_RELEASED;
	endproperty
	property p_double_order;
		take && ev_code == `EV_DOUBLE |-> last_q == `EV_PRESSED;
	endproperty
	property p_free_order;
		take && ev_code == `EV_FREE |-> last_q == `EV_RELEASED;
	endproperty
	a_ev_legal: assert property (p_ev_legal) else $error("unknown event code");
	a_ev_gap: assert property (p_ev_gap) else $error("event not spaced");
	a_frame_pulse: assert property (p_frame_pulse) else $error("frame strobe too long");
	a_twice_same: assert property (p_twice_same) else $error("repeat frame differs");
	a_reset_quiet: assert property (p_reset_quiet) else $error("link busy after reset");
	a_repeat_order: assert property (p_repeat_order) else $error("repeat out of order");
	a_stop_order: assert property (p_stop_order) else $error("stop out of order");
	a_double_order: assert property (p_double_order) else $error("double out of order");
	a_free_order: assert property (p_free_order) else $error("free out of order");
	// main scenarios reached
	c_double: cover property (take && ev_code == `EV_DOUBLE);
	c_long: cover property (take && ev_code == `EV_LONG_START);
	c_stuck: cover property (take && ev_code == `EV_STUCK);
endmodule
`default_nettype wire

// ---- dv/push_button_event_detector_bench.sv ----
// bench for the button event device and bus controller joined by the link
// assumes the design, defines header and link checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "button_event_defines.svh"
module push_button_event_detector_bench;
	localparam int TICKS = 10;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        key = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lamp_valid;
	logic [15:0] lamp_cmd;
	logic [7:0]  s_short;
	logic [7:0]  s_double;
	logic [7:0]  s_repeat;
	logic [7:0]  s_filter;
	int          miscompares = 0;
	int          checks = 0;
	logic [9:0]  evq[$];
	logic [15:0] lampq[$];
	event_link_if link ();
	button_event_device #(.TICK_CYCLES(TICKS), .STUCK_TICKS(20)) i_button_event_device (
		.I_CLK(clk), .I_SRST(srst), .I_TOUCH_KEY_INPUT(key), .link(link),
		.O_SHORT_SETTING(s_short), .O_DOUBLE_SETTING(s_double),
		.O_REPEAT_SETTING(s_repeat), .O_EVENT_FILTER(s_filter));
	event_bus_controller i_event_bus_controller (
		.I_CLK(clk), .I_SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .link(link), .O_LAMP_VALID(lamp_valid), .O_LAMP_CMD(lamp_cmd));
	push_button_event_detector_asserts i_push_button_event_detector_asserts (
		.I_CLK(clk), .I_SRST(srst), .frame_valid(link.frame_valid), .frame(link.frame),
		.ev_valid(link.ev_valid), .ev_code(link.ev_code), .ev_ready(link.ev_ready));
	// free running clock
	always #10 clk = ~clk;
	// collect events and lamp commands away from the clock edge
	always @(negedge clk) begin
		if ((link.ev_valid & link.ev_ready) === 1'b1)
			evq.push_back(link.ev_code);
		if (lamp_valid === 1'b1)
			lampq.push_back(lamp_cmd);
	end
	task automatic give_verdict();
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic chk_ev(input logic [9:0] e[$]);
		chk("event count", e.size(), evq.size());
		foreach (e[i])
			chk("event", e[i], evq[i]);
		evq.delete();
	endtask
	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (pready !== 1'b1) begin
			chk("pready", 1'b1, pready);
			give_verdict();
		end
	endtask
	// send one frame, once or twice, and wait until the controller is idle
	task automatic send(input logic [23:0] f, input logic tw);
		logic [31:0] r;
		logic        e;
		int          n;
		apb(1'b1, `REG_CMD, {7'h00, tw, f}, r, e);
		n = 0;
		do begin
			apb(1'b0, `REG_STATUS, 32'h0, r, e);
			n++;
		end while (r[0] !== 1'b0 && n < 20);
		if (r[0] !== 1'b0) begin
			chk("busy", 1'b0, r[0]);
			give_verdict();
		end
	endtask
	task automatic configure(input logic [7:0] v[4]);
		logic [23:0] c[4];
		c = '{`CMD_SET_SHORT, `CMD_SET_DOUBLE, 24'(`CMD_SET_REPEAT), 24'(`CMD_SET_FILTER)};
		for (int i = 0; i < 4; i++) begin
			send({`DTR0_PREFIX, v[i]}, 1'b0);
			send(c[i], 1'b1);
		end
		chk("short set", v[0], s_short);
		chk("double set", v[1], s_double);
		chk("repeat set", v[2], s_repeat);
		chk("filter set", v[3], s_filter);
	endtask
	// hold the key for some ticks, then leave it released for some ticks
	task automatic press(input int on, input int off);
		key <= 1'b1;
		repeat (on * TICKS) @(posedge clk);
		key <= 1'b0;
		repeat (off * TICKS) @(posedge clk);
	endtask
	task automatic chk_long(input logic [9:0] t[$]);
		int n;
		n = evq.size() - t.size();
		chk("pressed", `EV_PRESSED, evq[0]);
		chk("start", `EV_LONG_START, evq[1]);
		chk("repeats seen", 1'b1, n > 2);
		for (int i = 2; i < n; i++)
			chk("repeat", `EV_LONG_REPEAT, evq[i]);
		foreach (t[i])
			chk("tail", t[i], evq[n + i]);
		evq.delete();
	endtask
	// main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("short reset", 8'h32, s_short);
		chk("double reset", 8'h19, s_double);
		chk("repeat reset", 8'h0A, s_repeat);
		chk("filter reset", 8'h3C, s_filter);
		press(3, 30);
		chk_ev('{`EV_SHORT});
		chk("lamp short", `LAMP_LAST_ACTIVE, lampq.pop_front());
		configure('{8'h04, 8'h03, 8'h02, 8'hFF});
		send(`CMD_RESET, 1'b0);
		chk("one reset", 8'h04, s_short);
		send(`CMD_RESET, 1'b1);
		chk("two resets", 8'h3C, s_filter);
		apb(1'b0, `REG_CMD, 32'h0, r, e);
		chk("last frame", {8'h00, `CMD_RESET}, r);
		configure('{8'h04, 8'h03, 8'h02, 8'hFF});
		press(2, 1);
		press(2, 6);
		chk_ev('{`EV_PRESSED, `EV_RELEASED, `EV_PRESSED, `EV_DOUBLE, `EV_RELEASED});
		chk("lamp double", `LAMP_OFF, lampq.pop_front());
		apb(1'b0, `REG_EVENT, 32'h0, r, e);
		chk("last event", `EV_RELEASED, r[9:0]);
		apb(1'b0, `REG_STATUS, 32'h0, r, e);
		chk("event seen", 1'b1, r[1]);
		apb(1'b1, `REG_STATUS, 32'h00000002, r, e);
		apb(1'b0, `REG_STATUS, 32'h0, r, e);
		chk("seen cleared", 1'b0, r[1]);
		apb(1'b0, `REG_LAMP, 32'h0, r, e);
		chk("lamp reg", `LAMP_OFF, r[15:0]);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk("unmapped", 1'b1, e);
		press(9, 3);
		chk_long('{`EV_RELEASED, `EV_LONG_STOP});
		chk("lamp start", `LAMP_RECALL_MIN, lampq.pop_front());
		chk("lamp repeat", `LAMP_UP, lampq.pop_front());
		press(28, 3);
		chk_long('{`EV_STUCK, `EV_RELEASED, `EV_FREE});
		give_verdict();
	end
endmodule
`default_nettype wire
